// ---- tb/core_model.sv ----
// stack memory and jump target (pc_value xor JUMP_OFFSET) beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module core_model import seq_pkg::*; #(
    parameter logic [PC_WIDTH-1:0] JUMP_OFFSET = 16'h5A00
) (
    input wire logic clock,
    input wire logic stack_we,
    input wire logic [PC_WIDTH-1:0] stack_addr,
    input wire logic [7:0] stack_wdata,
    input wire logic [PC_WIDTH-1:0] pc_value,
    output logic [7:0] stack_rdata,
    output logic [PC_WIDTH-1:0] jump_target
);
    logic [7:0] mem [0:255];
    // unwritten cells hold an address-dependent pattern
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~i[7:0];
        end
    end
    always @(posedge clock) begin
        if (stack_we === 1'h1) begin
            mem[stack_addr[7:0]] <= stack_wdata;
        end
    end
    assign stack_rdata = mem[stack_addr[7:0]];
    assign jump_target = pc_value ^ JUMP_OFFSET;
endmodule : core_model
`default_nettype wire

// ---- tb/interrupt_sequencer_asserts.sv ----
// port-level checks for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module interrupt_sequencer_checker import seq_pkg::*; #(
    parameter int PC_W = PC_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic irq_pending,
    input wire logic instr_done,
    input wire logic sei_done,
    input wire logic reti_start,
    input wire logic core_hold,
    input wire logic irq_ack,
    input wire logic pc_load,
    input wire logic handler_start,
    input wire logic stack_we,
    input wire logic stack_re,
    input wire logic [PC_W-1:0] stack_pointer,
    input wire logic global_enable
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence take_s;
        !core_hold && instr_done && irq_pending && global_enable && !reti_start;
    endsequence
    sequence acked_s;
        irq_ack && $past(instr_done);
    endsequence
    sequence ret_s;
        !core_hold && reti_start;
    endsequence
    chk_accept_ack: assert property (take_s |=> irq_ack && core_hold)
        else $error("no acknowledge at boundary");
    chk_sei_delay: assert property (
        !core_hold && instr_done && sei_done && !global_enable
            |=> !irq_ack && global_enable)
        else $error("taken at enabling boundary");
    chk_entry_span: assert property (
        acked_s |-> core_hold [*7] ##1 !core_hold)
        else $error("entry hold length wrong");
    chk_push_pair: assert property (
        acked_s |=> stack_we ##1 stack_we ##1 !stack_we)
        else $error("push strobes wrong");
    chk_vector_jump: assert property (
        acked_s |-> ##3 pc_load && !handler_start ##3 pc_load && handler_start)
        else $error("vector or jump load misplaced");
    chk_entry_sp: assert property (
        acked_s |-> ##2 stack_pointer == $past(stack_pointer, 2)
            - PC_W'(SP_STEP) && !global_enable)
        else $error("entry stack pointer or enable wrong");
    chk_ret_span: assert property (ret_s |=> core_hold [*4] ##1 !core_hold)
        else $error("return length wrong");
    chk_ret_pops: assert property (
        ret_s |-> ##2 stack_re ##1 stack_re ##1 pc_load && !stack_re)
        else $error("return pops wrong");
    chk_ret_sp: assert property (
        ret_s |-> ##5 stack_pointer == $past(stack_pointer, 5) + PC_W'(SP_STEP))
        else $error("return stack pointer wrong");
    chk_ret_enable: assert property (ret_s |-> ##5 global_enable)
        else $error("enable not set by return");
    cover property (acked_s);
    cover property (ret_s);
    cover property ($rose(handler_start));
    cover property (irq_ack && !$past(instr_done));
endmodule : interrupt_sequencer_checker
bind interrupt_sequencer interrupt_sequencer_checker #(.PC_W(PC_W)) chk (
    .clock, .rst, .irq_pending, .instr_done, .sei_done, .reti_start,
    .core_hold, .irq_ack, .pc_load, .handler_start, .stack_we, .stack_re,
    .stack_pointer, .global_enable);
`default_nettype wire

// ---- tb/test_interrupt_sequencer.sv ----
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_sequencer import seq_pkg::*; ;
    logic clock, rst, irq_pending, instr_done, sei_done, cli_done;
    logic reti_start, sleeping, startup_done, sp_load, core_hold, irq_ack;
    logic pc_load, handler_start, stack_we, stack_re, global_enable;
    logic [15:0] irq_vector, pc_current, jump_target, sp_wdata, pc_value;
    logic [15:0] stack_addr, stack_pointer;
    logic [7:0] stack_rdata, stack_wdata;
    int fail_count = 0;
    int n_tests = 0;
    int n;
    interrupt_sequencer dut (.clock, .rst, .irq_pending, .irq_vector,
        .instr_done, .sei_done, .cli_done, .reti_start, .sleeping,
        .startup_done, .pc_current, .jump_target, .stack_rdata, .sp_load,
        .sp_wdata, .core_hold, .irq_ack, .pc_load, .pc_value, .handler_start,
        .stack_we, .stack_re, .stack_addr, .stack_wdata, .stack_pointer,
        .global_enable);
    core_model partner (.clock, .stack_we, .stack_addr, .stack_wdata,
        .pc_value, .stack_rdata, .jump_target);
    always #2.5 clock = ~clock;
    // ****
    // shared tasks
    // ****
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task automatic cmp(input logic [39:0] got, want, input string what);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, want);
        end
    endtask : cmp
    task automatic boundary(input logic sets);
        instr_done = 1'h1;
        sei_done = sets;
        tick(1);
        instr_done = 1'h0;
        sei_done = 1'h0;
    endtask : boundary
    task automatic entry(input logic [15:0] v, r, s);
        tick(1);
        cmp({stack_we, stack_wdata}, {1'h1, r[7:0]}, "p0");
        cmp(stack_addr, s, "a0");
        tick(1);
        cmp(stack_addr, s - 16'h0001, "a1");
        cmp({stack_we, stack_wdata}, {1'h1, r[15:8]}, "d1");
        cmp({global_enable, stack_pointer}, {1'h0, s - 16'h0002}, "sp");
        tick(1);
        cmp({pc_load, handler_start, pc_value}, {2'h2, v}, "vec");
        tick(3);
        cmp({pc_load, handler_start}, 2'h3, "j");
        cmp(pc_value, v ^ 16'h5A00, "jt");
        cmp(core_hold, 1'h1, "h7");
        tick(1);
        cmp(core_hold, 1'h0, "h8");
    endtask : entry
    task automatic ret_walk(input logic [15:0] r, s);
        reti_start = 1'h1;
        tick(1);
        reti_start = 1'h0;
        cmp({core_hold, stack_re}, 2'h2, "r0");
        tick(1);
        cmp({stack_re, stack_addr}, {1'h1, s + 16'h0001}, "r1");
        tick(1);
        cmp({stack_re, stack_addr}, {1'h1, s + 16'h0002}, "r2");
        tick(1);
        cmp({pc_load, pc_value}, {1'h1, r}, "pop");
        cmp({core_hold, stack_re}, 2'h2, "r4");
        tick(1);
        cmp({core_hold, global_enable}, 2'h1, "r5");
        cmp(stack_pointer, s + 16'h0002, "rsp");
    endtask : ret_walk
    // ****
    // scenarios
    // ****
    task automatic t_sei;
        sp_wdata = 16'h045F;
        sp_load = 1'h1;
        tick(1);
        sp_load = 1'h0;
        irq_vector = 16'h0002;
        pc_current = 16'h0123;
        irq_pending = 1'h1;
        boundary(1'h1);
        cmp({irq_ack, global_enable}, 2'h1, "sei");
        tick(1);
        boundary(1'h0);
        cmp(irq_ack, 1'h1, "take");
        entry(16'h0002, 16'h0123, 16'h045F);
        irq_pending = 1'h0;
        ret_walk(16'h0123, 16'h045D);
        $display("test sei and return done");
    endtask : t_sei
    task automatic t_multi;
        irq_vector = 16'h0004;
        pc_current = 16'h0456;
        irq_pending = 1'h1;
        for (int i = 0; i < 3; i++) begin
            tick(1);
            cmp({irq_ack, core_hold}, 2'h0, "busy");
        end
        boundary(1'h0);
        cmp(irq_ack, 1'h1, "take");
        entry(16'h0004, 16'h0456, 16'h045F);
        irq_pending = 1'h0;
        ret_walk(16'h0456, 16'h045D);
        $display("test multi-cycle done");
    endtask : t_multi
    task automatic t_wake;
        irq_vector = 16'h0006;
        pc_current = 16'h0789;
        sleeping = 1'h1;
        irq_pending = 1'h1;
        tick(1);
        cmp(irq_ack, 1'h1, "wake");
        tick(4);
        startup_done = 1'h1;
        n = 0;
        while (pc_load !== 1'h1 && n < 40) begin
            tick(1);
            n++;
        end
        cmp(n, int'(WAKE_EXTRA_LEN) + int'(ENTRY_LEN), "lat");
        cmp({pc_value, stack_pointer}, {16'h0006, 16'h045D}, "wv");
        irq_pending = 1'h0;
        tick(5);
        cmp(core_hold, 1'h0, "wh");
        sleeping = 1'h0;
        startup_done = 1'h0;
        ret_walk(16'h0789, 16'h045D);
        cli_done = 1'h1;
        boundary(1'h0);
        cli_done = 1'h0;
        cmp(global_enable, 1'h0, "cli");
        irq_pending = 1'h1;
        tick(1);
        boundary(1'h0);
        cmp({irq_ack, core_hold}, 2'h0, "off");
        irq_pending = 1'h0;
        $display("test wake done");
    endtask : t_wake
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        clock = 1'h0;
        rst = 1'h1;
        {irq_pending, instr_done, sei_done, cli_done, reti_start} = 5'h0;
        {sleeping, startup_done, sp_load} = 3'h0;
        {irq_vector, pc_current, sp_wdata} = 48'h0;
        tick(6);
        rst = 1'h0;
        cmp({core_hold, global_enable, stack_pointer}, 18'h0, "rst");
        $display("test reset done");
        t_sei();
        t_multi();
        t_wake();
        complete_run();
    end
    initial begin
        #10000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : test_interrupt_sequencer
`default_nettype wire

// ---- verilog/interrupt_sequencer.sv ----
// interrupt acceptance, vector entry, wake-up and return sequencer
`timescale 1ns/1ps
`default_nettype none
module interrupt_sequencer import seq_pkg::*; #(
    parameter int PC_W = PC_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic irq_pending,
    input wire logic [PC_W-1:0] irq_vector,
    input wire logic instr_done,
    input wire logic sei_done,
    input wire logic cli_done,
    input wire logic reti_start,
    input wire logic sleeping,
    input wire logic startup_done,
    input wire logic [PC_W-1:0] pc_current,
    input wire logic [PC_W-1:0] jump_target,
    input wire logic [7:0] stack_rdata,
    input wire logic sp_load,
    input wire logic [PC_W-1:0] sp_wdata,
    output logic core_hold,
    output logic irq_ack,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic handler_start,
    output logic stack_we,
    output logic stack_re,
    output logic [PC_W-1:0] stack_addr,
    output logic [7:0] stack_wdata,
    output logic [PC_W-1:0] stack_pointer,
    output logic global_enable
);

    // ********************************************************
    // state and registers
    // ********************************************************
    seq_state_t state_reg;
    seq_state_t state_next;
    logic gie_reg;
    logic gie_next;
    logic [PC_W-1:0] sp_reg;
    logic [PC_W-1:0] sp_next;
    logic [PC_W-1:0] ret_pc_reg;
    logic [PC_W-1:0] ret_pc_next;
    logic [PC_W-1:0] vector_reg;
    logic [PC_W-1:0] vector_next;
    logic [7:0] pop_hi_reg;
    logic [7:0] pop_hi_next;
    logic core_hold_reg;
    logic irq_ack_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_value_reg;
    logic [PC_W-1:0] pc_value_next;
    logic handler_start_reg;
    logic stack_we_reg;
    logic stack_re_reg;
    logic [PC_W-1:0] stack_addr_reg;
    logic [PC_W-1:0] stack_addr_next;
    logic [7:0] stack_wdata_reg;
    logic [7:0] stack_wdata_next;

    // ********************************************************
    // phase timer
    // ********************************************************
    phase_if ph ();

    phase_timer u_timer (
        .clock(clock),
        .rst(rst),
        .ph(ph.timer)
    );

    wire logic [PHASE_W-1:0] cur_len;
    wire logic [PHASE_W-1:0] next_len;
    wire logic [PHASE_W-1:0] phase;
    wire logic seq_last;

    assign cur_len = (state_reg == ST_JUMP) ? JUMP_LEN
        : (state_reg == ST_WAKE_EXTRA) ? WAKE_EXTRA_LEN
        : (state_reg == ST_RETURN) ? RETURN_LEN : ENTRY_LEN;
    assign next_len = (state_next == ST_JUMP) ? JUMP_LEN
        : (state_next == ST_WAKE_EXTRA) ? WAKE_EXTRA_LEN
        : (state_next == ST_RETURN) ? RETURN_LEN : ENTRY_LEN;
    assign phase = PHASE_W'(cur_len - 3'h1 - ph.remaining);
    assign seq_last = ph.remaining == {PHASE_W{1'b0}};
    assign ph.load = (state_next != state_reg) && (state_next != ST_IDLE)
        && (state_next != ST_WAKE_WAIT);
    assign ph.load_value = next_len;

    // ********************************************************
    // acceptance decode
    // ********************************************************
    wire logic in_idle;
    wire logic take_return;
    wire logic accept_now;
    wire logic wake_now;
    wire logic start_entry;
    wire logic sei_now;
    wire logic cli_now;
    wire logic sp_write;

    assign in_idle = state_reg == ST_IDLE;
    assign take_return = in_idle && reti_start;
    // global enable as set before this boundary, so a sei boundary that
    // finds it clear never accepts
    assign accept_now = in_idle && !reti_start && instr_done
        && irq_pending && gie_reg;
    assign wake_now = in_idle && !reti_start && !instr_done && sleeping
        && irq_pending && gie_reg;
    assign start_entry = accept_now || wake_now;
    assign sei_now = in_idle && sei_done;
    assign cli_now = in_idle && cli_done;
    assign sp_write = in_idle && sp_load;

    // ********************************************************
    // sequence actions
    // ********************************************************
    wire logic in_entry;
    wire logic in_return;
    wire logic push_lo;
    wire logic push_hi;
    wire logic entry_vector;
    wire logic jump_load;
    wire logic pop_hi;
    wire logic pop_lo;
    wire logic ret_load;
    wire logic ret_done;
    wire logic pc_load_now;
    wire logic push_now;
    wire logic pop_now;

    assign in_entry = state_reg == ST_ENTRY;
    assign in_return = state_reg == ST_RETURN;
    assign push_lo = in_entry && (phase == PH_PUSH_LO);
    assign push_hi = in_entry && (phase == PH_PUSH_HI);
    assign entry_vector = in_entry && (phase == PH_VECTOR);
    assign jump_load = (state_reg == ST_JUMP)
        && (phase == PH_JUMP_LOAD);
    assign pop_hi = in_return && (phase == PH_POP_HI);
    assign pop_lo = in_return && (phase == PH_POP_LO);
    assign ret_load = in_return && (phase == PH_RET_LOAD);
    assign ret_done = in_return && (phase == PH_RET_DONE);
    assign pc_load_now = entry_vector || jump_load || ret_load;
    assign push_now = push_lo || push_hi;
    assign pop_now = pop_hi || pop_lo;

    // ********************************************************
    // state machine
    // ********************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_return) begin
                    state_next = ST_RETURN;
                end else if (accept_now) begin
                    state_next = ST_ENTRY;
                end else if (wake_now) begin
                    state_next = ST_WAKE_WAIT;
                end
            end
            ST_WAKE_WAIT: begin
                if (startup_done) begin
                    state_next = ST_WAKE_EXTRA;
                end
            end
            ST_WAKE_EXTRA: begin
                if (seq_last) begin
                    state_next = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (seq_last) begin
                    state_next = ST_JUMP;
                end
            end
            ST_JUMP: begin
                if (seq_last) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RETURN: begin
                if (seq_last) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ********************************************************
    // global enable and stack pointer
    // ********************************************************
    assign gie_next = push_hi ? 1'b0
        : ret_done ? 1'b1
        : sei_now ? 1'b1
        : cli_now ? 1'b0 : gie_reg;
    assign sp_next = push_hi ? PC_W'(sp_reg - PC_W'(SP_STEP))
        : ret_done ? PC_W'(sp_reg + PC_W'(SP_STEP))
        : sp_write ? sp_wdata : sp_reg;

    // ********************************************************
    // captured addresses and popped byte
    // ********************************************************
    assign ret_pc_next = start_entry ? pc_current : ret_pc_reg;
    assign vector_next = start_entry ? irq_vector : vector_reg;
    assign pop_hi_next = pop_lo ? stack_rdata : pop_hi_reg;

    // ********************************************************
    // output values for the next cycle
    // ********************************************************
    assign stack_addr_next = push_lo ? sp_reg
        : push_hi ? PC_W'(sp_reg - PC_W'(1))
        : pop_hi ? PC_W'(sp_reg + PC_W'(1))
        : pop_lo ? PC_W'(sp_reg + PC_W'(SP_STEP)) : stack_addr_reg;
    assign stack_wdata_next = push_lo ? ret_pc_reg[7:0]
        : push_hi ? ret_pc_reg[PC_W-1:PC_W-8] : stack_wdata_reg;
    assign pc_value_next = entry_vector ? vector_reg
        : jump_load ? jump_target
        : ret_load ? {pop_hi_reg, stack_rdata} : pc_value_reg;

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            gie_reg <= GIE_RESET;
            sp_reg <= SP_RESET;
            ret_pc_reg <= PC_RESET;
            vector_reg <= PC_RESET;
            pop_hi_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            gie_reg <= gie_next;
            sp_reg <= sp_next;
            ret_pc_reg <= ret_pc_next;
            vector_reg <= vector_next;
            pop_hi_reg <= pop_hi_next;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            core_hold_reg <= 1'b0;
            irq_ack_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            pc_value_reg <= PC_RESET;
            handler_start_reg <= 1'b0;
        end else begin
            core_hold_reg <= state_next != ST_IDLE;
            irq_ack_reg <= start_entry;
            pc_load_reg <= pc_load_now;
            pc_value_reg <= pc_value_next;
            handler_start_reg <= jump_load;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stack_we_reg <= 1'b0;
            stack_re_reg <= 1'b0;
            stack_addr_reg <= SP_RESET;
            stack_wdata_reg <= 8'h00;
        end else begin
            stack_we_reg <= push_now;
            stack_re_reg <= pop_now;
            stack_addr_reg <= stack_addr_next;
            stack_wdata_reg <= stack_wdata_next;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign core_hold = core_hold_reg;
    assign irq_ack = irq_ack_reg;
    assign pc_load = pc_load_reg;
    assign pc_value = pc_value_reg;
    assign handler_start = handler_start_reg;
    assign stack_we = stack_we_reg;
    assign stack_re = stack_re_reg;
    assign stack_addr = stack_addr_reg;
    assign stack_wdata = stack_wdata_reg;
    assign stack_pointer = sp_reg;
    assign global_enable = gie_reg;

endmodule : interrupt_sequencer
`default_nettype wire

// ---- verilog/phase_if.sv ----
// phase counter link between sequencer and its timer
`timescale 1ns/1ps
`default_nettype none
interface phase_if import seq_pkg::*; ();
    logic load;
    logic [PHASE_W-1:0] load_value;
    logic [PHASE_W-1:0] remaining;
    modport timer (input load, input load_value, output remaining);
    modport user (output load, output load_value, input remaining);
endinterface : phase_if
`default_nettype wire

// ---- verilog/phase_timer.sv ----
// down counter giving the cycles left in a fixed-length sequence
`timescale 1ns/1ps
`default_nettype none
module phase_timer import seq_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    phase_if.timer ph
);

    logic [PHASE_W-1:0] remaining_reg;
    logic [PHASE_W-1:0] remaining_next;
    wire logic counting;

    assign counting = remaining_reg != {PHASE_W{1'b0}};
    assign remaining_next = ph.load ? PHASE_W'(ph.load_value - 3'h1)
        : counting ? PHASE_W'(remaining_reg - 3'h1) : {PHASE_W{1'b0}};
    assign ph.remaining = remaining_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            remaining_reg <= {PHASE_W{1'b0}};
        end else begin
            remaining_reg <= remaining_next;
        end
    end

endmodule : phase_timer
`default_nettype wire

// ---- verilog/seq_pkg.sv ----
// constants and types shared by the interrupt entry/return sequencer
package seq_pkg;

    // ********************************************************
    // widths
    // ********************************************************
    localparam int PC_WIDTH = 16;
    localparam int PHASE_W = 3;

    // ********************************************************
    // sequence lengths in clock cycles
    // ********************************************************
    localparam logic [PHASE_W-1:0] ENTRY_LEN = 3'h4;
    localparam logic [PHASE_W-1:0] JUMP_LEN = 3'h3;
    localparam logic [PHASE_W-1:0] WAKE_EXTRA_LEN = 3'h4;
    localparam logic [PHASE_W-1:0] RETURN_LEN = 3'h4;

    // ********************************************************
    // phases inside each sequence
    // ********************************************************
    localparam logic [PHASE_W-1:0] PH_PUSH_LO = 3'h0;
    localparam logic [PHASE_W-1:0] PH_PUSH_HI = 3'h1;
    localparam logic [PHASE_W-1:0] PH_VECTOR = 3'h2;
    localparam logic [PHASE_W-1:0] PH_JUMP_LOAD = 3'h1;
    localparam logic [PHASE_W-1:0] PH_POP_HI = 3'h0;
    localparam logic [PHASE_W-1:0] PH_POP_LO = 3'h1;
    localparam logic [PHASE_W-1:0] PH_RET_LOAD = 3'h2;
    localparam logic [PHASE_W-1:0] PH_RET_DONE = 3'h3;

    // ********************************************************
    // stack and reset values
    // ********************************************************
    localparam int SP_STEP = 2;
    localparam logic [PC_WIDTH-1:0] SP_RESET = 16'h0000;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
    localparam logic GIE_RESET = 1'h0;

    // ********************************************************
    // sequencer states
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ENTRY = 3'b001,
        ST_JUMP = 3'b010,
        ST_WAKE_WAIT = 3'b011,
        ST_WAKE_EXTRA = 3'b100,
        ST_RETURN = 3'b101
    } seq_state_t;

endpackage : seq_pkg
